/* bench/rps_far_side.sv */
// Far-side model: stage ready flags and the flash boot logic.
// Assumes the sequencer's enables and cfg_read_start pulse on sys_clk.
`timescale 1ns/1ps
module rps_far_side (
   // Clock
   input wire logic sys_clk,
   // Enables from the sequencer
   input wire logic slow_osc_1mhz,
   input wire logic buck_converter,
   input wire logic sys_domain_en,
   input wire logic ldo_en,
   input wire logic fast_osc_en,
   input wire logic cfg_read_start,
   input wire logic core_reset_n,
   // Bench controls
   input wire logic ready_stall,
   input wire logic prog_sel,
   // Ready flags and boot answers
   output logic slow_osc_ready,
   output logic buck_ready,
   output logic sys_domain_ready,
   output logic ldo_ready,
   output logic fast_osc_ready,
   output logic cfg_done,
   output logic cfg_prog_mode
);
   // ==========================================
   // Stage settling
   // A stage reports ready two edges after its enable; a stall drops all of them
   logic [4:0] en_d = 5'h00;
   always @(posedge sys_clk) begin
      en_d <= {fast_osc_en, ldo_en, sys_domain_en, buck_converter, slow_osc_1mhz};
      {fast_osc_ready, ldo_ready, sys_domain_ready, buck_ready, slow_osc_ready} <=
         ready_stall ? 5'h00 : en_d;
   end
   // ==========================================
   // Flash configuration read
   initial cfg_done = 1'h0;
   always @(posedge sys_clk) begin
      cfg_done <= cfg_read_start | (cfg_done & ~core_reset_n & fast_osc_en);
   end
   assign cfg_prog_mode = prog_sel;
endmodule : rps_far_side

/* bench/rps_sequencer_assertions.sv */
// Concurrent checks on the sequencer's ports.
// Assumes it is bound into every rps_sequencer instance.
`timescale 1ns/1ps
module rps_sequencer_assertions (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Reset causes
   input wire logic ext_reset_n_pin,
   input wire logic por_ok,
   input wire logic soft_reset_req,
   input wire logic sys_reset_req,
   input wire logic wdt_timeout,
   input wire logic wdt_reset_mode,
   // Enables
   input wire logic slow_osc_1mhz,
   input wire logic buck_converter,
   input wire logic sys_domain_en,
   input wire logic ldo_en,
   input wire logic fast_osc_en,
   input wire logic cpu_en,
   // Resets, boot, events
   input wire logic core_reset_n,
   input wire logic xtal_reset_n,
   input wire logic cfg_read_start,
   input wire logic boot_app,
   input wire logic in_system_programming_mode,
   input wire logic ram_invalid,
   input wire logic wdt_irq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // ==========================================
   // Power-up, boot and reset steps
   sequence s_run_req;
      sys_reset_req && core_reset_n;
   endsequence
   sequence s_spared;
      !cpu_en && !xtal_reset_n && !fast_osc_en && buck_converter && ldo_en && slow_osc_1mhz;
   endsequence
   a_sysrst_spares_domains: assert property (s_run_req |=> s_spared)
      else $error("system reset touched the supplies");
   a_buck_after_slow: assert property ($rose(buck_converter) |-> slow_osc_1mhz)
      else $error("buck started before slow oscillator");
   a_ldo_after_domain: assert property ($rose(ldo_en) |-> sys_domain_en && buck_converter)
      else $error("regulators enabled too early");
   a_cpu_after_fast: assert property ($rose(cpu_en) |-> fast_osc_en && ldo_en && cfg_read_start)
      else $error("processor enabled out of order");
   a_cfg_single_pulse: assert property (cfg_read_start |=> !cfg_read_start)
      else $error("config read pulse too long");
   a_boot_one_mode: assert property ($rose(core_reset_n) |-> boot_app ^ in_system_programming_mode)
      else $error("boot mode not exclusive");
   a_pin_holds_reset: assert property (!ext_reset_n_pin |=> !slow_osc_1mhz && !core_reset_n)
      else $error("pin low did not reset");
   a_por_holds_off: assert property (!por_ok [*3] |=> !slow_osc_1mhz && ram_invalid)
      else $error("sequence ran without supply");
   a_soft_full_reset: assert property (soft_reset_req |=> !cpu_en && !slow_osc_1mhz && ram_invalid)
      else $error("software reset incomplete");
   sequence s_wdt_irq_req;
      wdt_timeout && !wdt_reset_mode && core_reset_n;
   endsequence
   a_wdt_irq_only: assert property (s_wdt_irq_req |=> wdt_irq && core_reset_n)
      else $error("watchdog interrupt mode wrong");
endmodule : rps_sequencer_assertions

bind rps_sequencer rps_sequencer_assertions i_rps_sequencer_assertions (.*);

/* bench/rps_sequencer_tb_top.sv */
// Self-checking bench for the reset and power-up sequencer.
// Assumes short settle counts; the far-side model answers readies and config.
`timescale 1ns/1ps
module rps_sequencer_tb_top;
   import rps_pkg::*;
   logic sys_clk = 1'h0;
   logic resetn = 1'h0;
   logic ext_reset_n_pin = 1'h1, por_ok = 1'h1, brownout_ok = 1'h1, brownout_warn = 1'h0;
   logic soft_reset_req = 1'h0, sys_reset_req = 1'h0, wdt_timeout = 1'h0, wdt_reset_mode = 1'h0;
   logic brownout_irq_en = 1'h0, ram_init_done = 1'h0, ready_stall = 1'h0, prog_sel = 1'h0;
   logic [BROWNOUT_THR_W-1:0] brownout_threshold_cfg = 3'h0, brownout_threshold;
   logic slow_osc_ready, buck_ready, sys_domain_ready, ldo_ready, fast_osc_ready;
   logic cfg_done, cfg_prog_mode;
   logic slow_osc_1mhz, buck_converter, sys_domain_en, ldo_en, fast_osc_en, cpu_en, boot_app;
   logic core_reset_n, periph_reset_n, xtal_reset_n, cfg_read_start, in_system_programming_mode;
   logic ram_invalid, brownout_irq, wdt_irq;
   int errors = 0;
   int comparisons = 0;
   rps_sequencer #(.SETTLE_CYCLES(2), .SYSRST_CYCLES(3)) i_rps_sequencer (.*);
   rps_far_side i_rps_far_side (.*);
   always #50 sys_clk = ~sys_clk;
   // ==========================================
   // Shared tasks
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask : check
   task automatic finish_test;
      $display("Counts: %0d comparisons, %0d errors", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : finish_test
   task automatic cycles(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : cycles
   // Bounded wait for boot, then the whole chain and the mode must stand
   task automatic wait_boot;
      int n;
      n = 0;
      while (core_reset_n !== 1'h1 && n < 300) begin
         cycles(1);
         n++;
      end
      if (core_reset_n !== 1'h1) begin
         errors++;
         $display("[ERR] %0t boot timeout", $time);
         finish_test();
      end
      check({slow_osc_1mhz, buck_converter, sys_domain_en, ldo_en, fast_osc_en, cpu_en,
         xtal_reset_n, periph_reset_n}, 8'hff, "chain not up");
      check({boot_app, in_system_programming_mode}, {~prog_sel, prog_sel}, "boot mode");
      ram_init_done = 1'h1;
      cycles(1);
      ram_init_done = 1'h0;
      check(ram_invalid, 1'h0, "ram flag stuck");
   endtask : wait_boot
   // ==========================================
   // Scenarios
   // Index 0 supply, 1 brownout, 2 pin held, 3 one-cycle pin pulse
   task automatic t_hold(input int idx, input int len);
      {por_ok, brownout_ok, ext_reset_n_pin} = ~(3'h4 >> (idx > 2 ? 2 : idx));
      prog_sel = idx[0];
      cycles(len);
      check({slow_osc_1mhz, core_reset_n, ram_invalid}, 3'h1, "not held in reset");
      {por_ok, brownout_ok, ext_reset_n_pin} = 3'h7;
      wait_boot();
      $display("test hold %0d done", idx);
   endtask : t_hold
   task automatic t_soft;
      soft_reset_req = 1'h1;
      cycles(1);
      soft_reset_req = 1'h0;
      check({slow_osc_1mhz, cpu_en, ram_invalid}, 3'h1, "soft reset partial");
      wait_boot();
      $display("test soft done");
   endtask : t_soft
   // Readies stall meanwhile, so the fast stage must wait for them
   task automatic t_sys;
      ready_stall = 1'h1;
      sys_reset_req = 1'h1;
      cycles(1);
      sys_reset_req = 1'h0;
      cycles(1);
      check({cpu_en, core_reset_n, xtal_reset_n, ram_invalid, slow_osc_1mhz, buck_converter,
         sys_domain_en, ldo_en}, 8'h0f, "system reset scope");
      cycles(20);
      check(cpu_en, 1'h0, "started without ready");
      ready_stall = 1'h0;
      wait_boot();
      $display("test system reset done");
   endtask : t_sys
   task automatic t_wdt;
      wdt_timeout = 1'h1;
      cycles(1);
      wdt_timeout = 1'h0;
      check({wdt_irq, core_reset_n}, 2'h3, "watchdog interrupt");
      cycles(1);
      check(wdt_irq, 1'h0, "interrupt too long");
      wdt_reset_mode = 1'h1;
      wdt_timeout = 1'h1;
      cycles(1);
      wdt_timeout = 1'h0;
      wdt_reset_mode = 1'h0;
      check({core_reset_n, ram_invalid, slow_osc_1mhz, wdt_irq}, 4'h4, "watchdog reset");
      wait_boot();
      $display("test watchdog done");
   endtask : t_wdt
   task automatic t_bod_irq;
      int hits;
      hits = 0;
      brownout_threshold_cfg = 3'h5;
      // First pass disabled, second enabled; warn falls and settles between
      for (int en = 0; en < 2; en++) begin
         brownout_irq_en = en[0];
         brownout_warn = 1'h1;
         hits = 0;
         repeat (8) begin
            cycles(1);
            hits += brownout_irq;
         end
         check(hits, en, "brownout interrupt count");
         brownout_warn = 1'h0;
         cycles(4);
      end
      check(brownout_threshold, 3'h5, "threshold copy");
      $display("test brownout interrupt done");
   endtask : t_bod_irq
   initial begin
      cycles(4);
      resetn = 1'h1;
      wait_boot();
      t_bod_irq();
      for (int i = 0; i < 4; i++)
         t_hold(i, i == 3 ? 1 : 6);
      t_soft();
      t_sys();
      t_wdt();
      finish_test();
   end
endmodule : rps_sequencer_tb_top

/* src/rps_pkg.sv */
// Constants and state encoding for the reset and power-up sequencer.
// Assumes a single 10 MHz sequencer clock and no software-visible registers.
package rps_pkg;

   // ==========================================================
   // Clock and timing
   localparam int SYS_CLK_HZ = 10_000_000;
   // Margin for a fast-running sequencer oscillator, in percent
   localparam int OSC_TOL_PCT = 15;
   // Least settle time after each stage reports ready
   localparam int STAGE_SETTLE_NS = 2000;
   // Least time the core is held in reset on a processor request
   localparam int SYSRST_HOLD_NS = 5000;
   localparam int SETTLE_CYC_RAW = (STAGE_SETTLE_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int SYSRST_CYC_RAW = (SYSRST_HOLD_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int SETTLE_CYC = (SETTLE_CYC_RAW * (100 + OSC_TOL_PCT) + 99) / 100;
   localparam int SYSRST_CYC = (SYSRST_CYC_RAW * (100 + OSC_TOL_PCT) + 99) / 100;
   localparam int TMR_W = 8;
   localparam int BROWNOUT_THR_W = 3;
   localparam logic [BROWNOUT_THR_W-1:0] BROWNOUT_THR_RESET = 3'h0;

   // ==========================================================
   // Sequencer states, Gray coded along the power-up path
   typedef enum logic [3:0] {
      ST_OFF    = 4'h0,
      ST_SLOW   = 4'h1,
      ST_BUCK   = 4'h3,
      ST_DOMAIN = 4'h2,
      ST_LDO    = 4'h6,
      ST_FAST   = 4'h7,
      ST_CFG    = 4'h5,
      ST_RUN    = 4'h4,
      ST_SYSRST = 4'hC
   } rps_state_t;

endpackage : rps_pkg

/* src/rps_sequencer.sv */
// Reset and power-up sequencer: merges reset sources and steps the supplies,
// oscillators and processor through start-up and boot.
// Assumes stage ready flags, supply monitors and the reset pin are asynchronous;
// processor, watchdog and boot-logic signals are on sys_clk.
`timescale 1ns/1ps
module rps_sequencer
   import rps_pkg::*;
#(
   parameter int SETTLE_CYCLES = SETTLE_CYC,
   parameter int SYSRST_CYCLES = SYSRST_CYC
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // External pin and supply monitors
   input wire logic ext_reset_n_pin,
   input wire logic por_ok,
   input wire logic brownout_ok,
   input wire logic brownout_warn,
   // Stage ready flags
   input wire logic slow_osc_ready,
   input wire logic buck_ready,
   input wire logic sys_domain_ready,
   input wire logic ldo_ready,
   input wire logic fast_osc_ready,
   // Processor and watchdog requests
   input wire logic soft_reset_req,
   input wire logic sys_reset_req,
   input wire logic wdt_timeout,
   input wire logic wdt_reset_mode,
   // Brownout configuration
   input wire logic brownout_irq_en,
   input wire logic [BROWNOUT_THR_W-1:0] brownout_threshold_cfg,
   // Boot logic
   input wire logic cfg_done,
   input wire logic cfg_prog_mode,
   input wire logic ram_init_done,
   // Stage enables
   output logic slow_osc_1mhz,
   output logic buck_converter,
   output logic sys_domain_en,
   output logic ldo_en,
   output logic fast_osc_en,
   output logic cpu_en,
   // Resets and boot
   output logic core_reset_n,
   output logic periph_reset_n,
   output logic xtal_reset_n,
   output logic cfg_read_start,
   output logic boot_app,
   output logic in_system_programming_mode,
   output logic ram_invalid,
   // Events and brownout setting
   output logic brownout_irq,
   output logic wdt_irq,
   output logic [BROWNOUT_THR_W-1:0] brownout_threshold
);

   if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << TMR_W) ||
       SYSRST_CYCLES < 1 || SYSRST_CYCLES >= (1 << TMR_W)) begin : g_bad_count
      $error("rps_sequencer: cycle count out of range");
   end

   localparam logic [TMR_W-1:0] SETTLE_LAST = TMR_W'(SETTLE_CYCLES - 1);
   localparam logic [TMR_W-1:0] SYSRST_LAST = TMR_W'(SYSRST_CYCLES - 1);

   // ==========================================================
   // Reset pin synchroniser
   // Async assert, sync release
   logic pin_meta;
   logic pin_sync;
   always_ff @(posedge sys_clk or negedge resetn or negedge ext_reset_n_pin) begin
      if (!resetn || !ext_reset_n_pin) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
      end else begin
         pin_meta <= 1'b1;
         pin_sync <= pin_meta;
      end
   end

   // ==========================================================
   // Two-stage synchronisers for asynchronous levels
   localparam int NSYNC = 8;
   logic [NSYNC-1:0] async_in;
   logic [NSYNC-1:0] sync_meta;
   logic [NSYNC-1:0] sync_q;
   assign async_in = {por_ok, brownout_ok, brownout_warn, slow_osc_ready,
                      buck_ready, sys_domain_ready, ldo_ready, fast_osc_ready};
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sync_meta <= '0;
         sync_q <= '0;
      end else begin
         sync_meta <= async_in;
         sync_q <= sync_meta;
      end
   end

   logic por_s, brown_s, warn_s, slow_s, buck_s, dom_s, ldo_s, fast_s;
   assign {por_s, brown_s, warn_s, slow_s, buck_s, dom_s, ldo_s, fast_s} = sync_q;

   // ==========================================================
   // State
   typedef struct packed {
      rps_state_t state;
      logic [TMR_W-1:0] tmr;
      logic warn_q;
      logic slow_osc_1mhz;
      logic buck_converter;
      logic sys_domain_en;
      logic ldo_en;
      logic fast_osc_en;
      logic cpu_en;
      logic core_reset_n;
      logic periph_reset_n;
      logic xtal_reset_n;
      logic cfg_read_start;
      logic boot_app;
      logic prog_mode;
      logic ram_invalid;
      logic brownout_irq;
      logic wdt_irq;
      logic [BROWNOUT_THR_W-1:0] brown_thr;
   } rps_regs_t;

   rps_regs_t r;
   rps_regs_t next_r;

   function automatic logic settled(input logic ready, input logic [TMR_W-1:0] tmr,
                                    input logic [TMR_W-1:0] last);
      settled = ready && (tmr == last);
   endfunction : settled

   logic full_reset;

   always_comb begin
      next_r = r;
      next_r.brownout_irq = 1'b0;
      next_r.wdt_irq = 1'b0;
      next_r.cfg_read_start = 1'b0;
      next_r.warn_q = warn_s;
      next_r.brown_thr = brownout_threshold_cfg;
      full_reset = !por_s || !brown_s || !pin_sync || soft_reset_req ||
                   (wdt_timeout && wdt_reset_mode);
      if (wdt_timeout && !wdt_reset_mode && r.state == ST_RUN) begin
         next_r.wdt_irq = 1'b1;
      end
      if (brownout_irq_en && r.state == ST_RUN && warn_s && !r.warn_q) begin
         next_r.brownout_irq = 1'b1;
      end
      // Counter advances every cycle; a stage state clears it while its ready is low, CFG and RUN hold it at zero
      next_r.tmr = r.tmr + TMR_W'(1);
      if (full_reset) begin
         next_r.state = ST_OFF;
         next_r.tmr = '0;
         next_r.slow_osc_1mhz = 1'b0;
         next_r.buck_converter = 1'b0;
         next_r.sys_domain_en = 1'b0;
         next_r.ldo_en = 1'b0;
         next_r.fast_osc_en = 1'b0;
         next_r.cpu_en = 1'b0;
         next_r.core_reset_n = 1'b0;
         next_r.periph_reset_n = 1'b0;
         next_r.xtal_reset_n = 1'b0;
         next_r.boot_app = 1'b0;
         next_r.prog_mode = 1'b0;
         next_r.brownout_irq = 1'b0;
         next_r.wdt_irq = 1'b0;
      end else begin
         case (r.state)
            ST_OFF: begin
               next_r.slow_osc_1mhz = 1'b1;
               next_r.state = ST_SLOW;
               next_r.tmr = '0;
            end
            ST_SLOW: begin
               if (!slow_s) begin
                  next_r.tmr = '0;
               end else if (settled(slow_s, r.tmr, SETTLE_LAST)) begin
                  next_r.buck_converter = 1'b1;
                  next_r.state = ST_BUCK;
                  next_r.tmr = '0;
               end
            end
            ST_BUCK: begin
               if (!buck_s) begin
                  next_r.tmr = '0;
               end else if (settled(buck_s, r.tmr, SETTLE_LAST)) begin
                  next_r.sys_domain_en = 1'b1;
                  next_r.state = ST_DOMAIN;
                  next_r.tmr = '0;
               end
            end
            ST_DOMAIN: begin
               if (!dom_s) begin
                  next_r.tmr = '0;
               end else if (settled(dom_s, r.tmr, SETTLE_LAST)) begin
                  next_r.ldo_en = 1'b1;
                  next_r.state = ST_LDO;
                  next_r.tmr = '0;
               end
            end
            ST_LDO: begin
               if (!ldo_s) begin
                  next_r.tmr = '0;
               end else if (settled(ldo_s, r.tmr, SETTLE_LAST)) begin
                  next_r.fast_osc_en = 1'b1;
                  next_r.xtal_reset_n = 1'b1;
                  next_r.state = ST_FAST;
                  next_r.tmr = '0;
               end
            end
            ST_FAST: begin
               if (!fast_s) begin
                  next_r.tmr = '0;
               end else if (settled(fast_s, r.tmr, SETTLE_LAST)) begin
                  next_r.cpu_en = 1'b1;
                  next_r.periph_reset_n = 1'b1;
                  next_r.cfg_read_start = 1'b1;
                  next_r.state = ST_CFG;
                  next_r.tmr = '0;
               end
            end
            ST_CFG: begin
               next_r.tmr = '0;
               if (cfg_done) begin
                  next_r.boot_app = !cfg_prog_mode;
                  next_r.prog_mode = cfg_prog_mode;
                  next_r.core_reset_n = 1'b1;
                  next_r.state = ST_RUN;
               end
            end
            ST_RUN: begin
               next_r.tmr = '0;
               if (sys_reset_req) begin
                  next_r.state = ST_SYSRST;
                  next_r.cpu_en = 1'b0;
                  next_r.core_reset_n = 1'b0;
                  next_r.periph_reset_n = 1'b0;
                  next_r.xtal_reset_n = 1'b0;
                  next_r.fast_osc_en = 1'b0;
                  next_r.boot_app = 1'b0;
                  next_r.prog_mode = 1'b0;
               end
            end
            ST_SYSRST: begin
               if (r.tmr == SYSRST_LAST) begin
                  next_r.fast_osc_en = 1'b1;
                  next_r.xtal_reset_n = 1'b1;
                  next_r.state = ST_FAST;
                  next_r.tmr = '0;
               end
            end
            default: begin
               next_r.state = ST_OFF;
               next_r.tmr = '0;
            end
         endcase
      end
      // RAM marked invalid; a new reset wins over the clear
      if (full_reset) begin
         next_r.ram_invalid = 1'b1;
      end else if (ram_init_done) begin
         next_r.ram_invalid = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         r <= '{state: ST_OFF, tmr: '0, ram_invalid: 1'b1,
                brown_thr: BROWNOUT_THR_RESET, default: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   // ==========================================================
   // Outputs
   assign slow_osc_1mhz = r.slow_osc_1mhz;
   assign buck_converter = r.buck_converter;
   assign sys_domain_en = r.sys_domain_en;
   assign ldo_en = r.ldo_en;
   assign fast_osc_en = r.fast_osc_en;
   assign cpu_en = r.cpu_en;
   assign core_reset_n = r.core_reset_n;
   assign periph_reset_n = r.periph_reset_n;
   assign xtal_reset_n = r.xtal_reset_n;
   assign cfg_read_start = r.cfg_read_start;
   assign boot_app = r.boot_app;
   assign in_system_programming_mode = r.prog_mode;
   assign ram_invalid = r.ram_invalid;
   assign brownout_irq = r.brownout_irq;
   assign wdt_irq = r.wdt_irq;
   assign brownout_threshold = r.brown_thr;

endmodule : rps_sequencer
